// File: spd_regs.svh
// Purpose: Addresses, page codes and reset values for the special register page decoder.
// Assumes: Direct special-register addresses are 8 bits, 0x80 to 0xFF.
// Notes: Definitions only.
//
// Behaviour
// - Page-select register at 0xA7, read/write, reachable from any page.
// - Page-select value chooses target page for every read, write, modify of 0xDE, 0x99, 0x9B, 0x9D.
// - After reset accesses go to page 0x0 until software changes it.
// - Address 0xDE: scan end channel on page 0x0, power management on 0xF.
// - Address 0x99: port 0 drive on page 0xF, serial buffer on 0x0.
// - Address 0x9B: port 1 drive on page 0xF, comparator control on 0x0.
// - Address 0x9D: port 2 drive on page 0xF, comparator mode on 0x0.
// - Extended interrupt enables at 0xE6, 0xE7 decode the same on all pages.
// - Extended interrupt priorities at 0xF6, 0xF7 decode the same on all pages.
// - Flash write-only register at 0xE5 decodes on every page.
// - Current reference config at 0xB9 on every page; page 0 neighbours unchanged.
// - Checksum sector count at 0x9A decodes on every page.
// - Converter burst power-up time at 0xBB decodes on every page.
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

`define SPD_PAGE_RESET       8'h00
`define SPD_PAGE_0           8'h00
`define SPD_PAGE_F           8'h0F

`define SPD_ADDR_PAGE_SEL    8'hA7
`define SPD_ADDR_SCAN_PM     8'hDE
`define SPD_ADDR_P0_SBUF     8'h99
`define SPD_ADDR_P1_CPTCN    8'h9B
`define SPD_ADDR_P2_CPTMD    8'h9D
`define SPD_ADDR_IRQ_EN1     8'hE6
`define SPD_ADDR_IRQ_EN2     8'hE7
`define SPD_ADDR_IRQ_PRI1    8'hF6
`define SPD_ADDR_IRQ_PRI2    8'hF7
`define SPD_ADDR_FLASH_WR    8'hE5
`define SPD_ADDR_IREF_CFG    8'hB9
`define SPD_ADDR_CRC_CNT     8'h9A
`define SPD_ADDR_BURST_PWR   8'hBB

`define SPD_RDATA_UNMAPPED   8'h00

`endif

// File: spd_pkg.sv
// Purpose: Types shared by the special register page decoder.
// Assumes: One target is decoded per access.
// Notes: Target codes are the index of the matching select strobe.
package spd_pkg;

  typedef enum logic [4:0] {
    SPD_TGT_NONE          = 5'h00,
    SPD_TGT_PAGE_SEL      = 5'h01,
    SPD_TGT_SCAN_END      = 5'h02,
    SPD_TGT_SENSE_PM      = 5'h03,
    SPD_TGT_PORT0_DRIVE   = 5'h04,
    SPD_TGT_SERIAL_BUF    = 5'h05,
    SPD_TGT_PORT1_DRIVE   = 5'h06,
    SPD_TGT_CMP_CONTROL   = 5'h07,
    SPD_TGT_PORT2_DRIVE   = 5'h08,
    SPD_TGT_CMP_MODE      = 5'h09,
    SPD_TGT_IRQ_EN1       = 5'h0A,
    SPD_TGT_IRQ_EN2       = 5'h0B,
    SPD_TGT_IRQ_PRI1      = 5'h0C,
    SPD_TGT_IRQ_PRI2      = 5'h0D,
    SPD_TGT_FLASH_WR      = 5'h0E,
    SPD_TGT_IREF_CFG      = 5'h0F,
    SPD_TGT_CRC_CNT       = 5'h10,
    SPD_TGT_BURST_PWR     = 5'h11
  } spd_target_t;

endpackage : spd_pkg

// File: spd_page_decoder.sv
// Purpose: Page-select register and paged decoder for direct special-register accesses.
// Assumes: The core drives address, strobes and write data on clk; peripheral read data is combinational.
// Notes: Read data returns one cycle after the read strobe, marked by rdata_valid.
`timescale 1ns/1ps
`include "spd_regs.svh"

module spd_page_decoder (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Core access port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_rd,
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  output logic                   sfr_rdata_valid,
  // Peripheral side
  input  wire logic [7:0]        periph_rdata,
  output spd_pkg::spd_target_t   periph_target,
  output logic                   periph_rd,
  output logic                   periph_wr,
  output logic [7:0]             periph_wdata,
  // Current page
  output logic [7:0]             page_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Page-select register.

  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;

  wire hit_page_sel = (sfr_addr == `SPD_ADDR_PAGE_SEL);
  wire page_wr      = sfr_wr && hit_page_sel;

  assign page_next = page_wr ? sfr_wdata : page_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      page_reg <= `SPD_PAGE_RESET;
    else
      page_reg <= page_next;
  end

  assign page_select = page_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  // Page values other than 0x0 and 0xF reach only the registers common to all pages.

  wire on_page0 = (page_reg == `SPD_PAGE_0);
  wire on_pagef = (page_reg == `SPD_PAGE_F);

  spd_pkg::spd_target_t paged_tgt;
  spd_pkg::spd_target_t common_tgt;

  always_comb
  begin
    paged_tgt = spd_pkg::SPD_TGT_NONE;
    unique case (sfr_addr)
      `SPD_ADDR_SCAN_PM:
        paged_tgt = on_pagef ? spd_pkg::SPD_TGT_SENSE_PM :
                    on_page0 ? spd_pkg::SPD_TGT_SCAN_END : spd_pkg::SPD_TGT_NONE;
      // Port 0 drive or serial buffer
      `SPD_ADDR_P0_SBUF:
        paged_tgt = on_pagef ? spd_pkg::SPD_TGT_PORT0_DRIVE :
                    on_page0 ? spd_pkg::SPD_TGT_SERIAL_BUF : spd_pkg::SPD_TGT_NONE;
      // Port 1 drive or comparator control
      `SPD_ADDR_P1_CPTCN:
        paged_tgt = on_pagef ? spd_pkg::SPD_TGT_PORT1_DRIVE :
                    on_page0 ? spd_pkg::SPD_TGT_CMP_CONTROL : spd_pkg::SPD_TGT_NONE;
      // Port 2 drive or comparator mode
      `SPD_ADDR_P2_CPTMD:
        paged_tgt = on_pagef ? spd_pkg::SPD_TGT_PORT2_DRIVE :
                    on_page0 ? spd_pkg::SPD_TGT_CMP_MODE : spd_pkg::SPD_TGT_NONE;
      default:
        paged_tgt = spd_pkg::SPD_TGT_NONE;
    endcase
  end

  // Common registers ignore the page value entirely.
  always_comb
  begin
    common_tgt = spd_pkg::SPD_TGT_NONE;
    unique case (sfr_addr)
      `SPD_ADDR_PAGE_SEL:  common_tgt = spd_pkg::SPD_TGT_PAGE_SEL;
      `SPD_ADDR_IRQ_EN1:   common_tgt = spd_pkg::SPD_TGT_IRQ_EN1;
      `SPD_ADDR_IRQ_EN2:   common_tgt = spd_pkg::SPD_TGT_IRQ_EN2;
      `SPD_ADDR_IRQ_PRI1:  common_tgt = spd_pkg::SPD_TGT_IRQ_PRI1;
      `SPD_ADDR_IRQ_PRI2:  common_tgt = spd_pkg::SPD_TGT_IRQ_PRI2;
      `SPD_ADDR_FLASH_WR:  common_tgt = spd_pkg::SPD_TGT_FLASH_WR;
      `SPD_ADDR_IREF_CFG:  common_tgt = spd_pkg::SPD_TGT_IREF_CFG;
      `SPD_ADDR_CRC_CNT:   common_tgt = spd_pkg::SPD_TGT_CRC_CNT;
      `SPD_ADDR_BURST_PWR: common_tgt = spd_pkg::SPD_TGT_BURST_PWR;
      default:             common_tgt = spd_pkg::SPD_TGT_NONE;
    endcase
  end

  wire is_common = (common_tgt != spd_pkg::SPD_TGT_NONE);
  wire is_mapped = (periph_target != spd_pkg::SPD_TGT_NONE);

  assign periph_target = is_common ? common_tgt : paged_tgt;
  // The page register lives here, so its accesses are not forwarded.
  wire   to_periph     = is_mapped && !hit_page_sel;
  assign periph_rd     = sfr_rd && to_periph;
  assign periph_wr     = sfr_wr && to_periph;
  assign periph_wdata  = sfr_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Read return path.

  wire [7:0] rd_mux = hit_page_sel ? page_reg :
                      to_periph    ? periph_rdata : `SPD_RDATA_UNMAPPED;

  assign rdata_next = sfr_rd ? rd_mux : rdata_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_reg  <= `SPD_RDATA_UNMAPPED;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= sfr_rd;
    end
  end

  assign sfr_rdata       = rdata_reg;
  assign sfr_rdata_valid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_page_write_next: assert property (
    page_wr |=> (page_reg == $past(sfr_wdata)))
    else $error("page write not effective next cycle");

  a_page_holds: assert property (
    !page_wr |=> (page_reg == $past(page_reg)))
    else $error("page changed without a write");

  a_page_readback: assert property (
    (sfr_rd && hit_page_sel) |=> (sfr_rdata_valid && sfr_rdata == $past(page_reg)))
    else $error("page register readback wrong");

  a_de_decode: assert property (
    (sfr_addr == `SPD_ADDR_SCAN_PM) |->
      (on_page0 ? periph_target == spd_pkg::SPD_TGT_SCAN_END :
       on_pagef ? periph_target == spd_pkg::SPD_TGT_SENSE_PM : !is_mapped))
    else $error("0xDE decode wrong");

  a_p0_decode: assert property (
    (sfr_addr == `SPD_ADDR_P0_SBUF && on_pagef) |-> periph_target == spd_pkg::SPD_TGT_PORT0_DRIVE)
    else $error("0x99 page F decode wrong");

  a_p1_decode: assert property (
    (sfr_addr == `SPD_ADDR_P1_CPTCN && on_page0) |-> periph_target == spd_pkg::SPD_TGT_CMP_CONTROL)
    else $error("0x9B page 0 decode wrong");

  a_p2_decode: assert property (
    (sfr_addr == `SPD_ADDR_P2_CPTMD && on_pagef) |-> periph_target == spd_pkg::SPD_TGT_PORT2_DRIVE)
    else $error("0x9D page F decode wrong");

  a_common_irq: assert property (
    (sfr_addr == `SPD_ADDR_IRQ_EN2) |-> periph_target == spd_pkg::SPD_TGT_IRQ_EN2)
    else $error("0xE7 not common");

  a_common_pri: assert property (
    (sfr_addr == `SPD_ADDR_IRQ_PRI1) |-> periph_target == spd_pkg::SPD_TGT_IRQ_PRI1)
    else $error("0xF6 not common");

  a_write_strobe: assert property (
    (sfr_wr && on_pagef && sfr_addr == `SPD_ADDR_P1_CPTCN) |->
      (periph_wr && periph_target == spd_pkg::SPD_TGT_PORT1_DRIVE))
    else $error("page F write to 0x9B not forwarded");

  a_rd_latency: assert property (
    (sfr_rd && to_periph) |=> (sfr_rdata_valid && sfr_rdata == $past(periph_rdata)))
    else $error("peripheral read data not returned next cycle");

  c_enter_pagef: cover property (page_wr && sfr_wdata == `SPD_PAGE_F ##1 on_pagef);
  c_pagef_write: cover property (on_pagef && periph_wr && periph_target == spd_pkg::SPD_TGT_PORT1_DRIVE);
  c_back_page0:  cover property (on_pagef ##1 page_wr && sfr_wdata == `SPD_PAGE_0 ##1 on_page0);
  c_common_rd:   cover property (on_pagef && periph_rd && periph_target == spd_pkg::SPD_TGT_CRC_CNT);

endmodule : spd_page_decoder

// File: spd_core_model.sv
// Purpose: Processor core model issuing direct special-register accesses.
// Assumes: One access per clock; strobes are one-cycle pulses taken at the edge.
// Notes: Idle write data is inverted so a stale byte never looks valid.
`timescale 1ns/1ps

module spd_core_model (
  // Clock
  input  wire logic       clk,
  // Access port
  output logic      [7:0] sfr_addr,
  output logic            sfr_rd,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata
);
  // Global interrupt enable as the core keeps it around page 0xF work.
  logic global_irq_enable;
  logic irq_enable_saved;

  initial
  begin
    global_irq_enable = 1'h1;
    irq_enable_saved  = 1'h1;
    sfr_addr  = 8'h80;
    sfr_rd    = 1'h0;
    sfr_wr    = 1'h0;
    sfr_wdata = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // Launch one access after an edge; the decoder takes it at the next edge.
  task automatic issue(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_rd    <= rd;
    sfr_wr    <= wr;
    sfr_addr  <= a;
    sfr_wdata <= d;
  endtask : issue

  task automatic idle();
    @(posedge clk);
    sfr_rd    <= 1'h0;
    sfr_wr    <= 1'h0;
    sfr_wdata <= ~sfr_wdata;
  endtask : idle

  task automatic irq_save();
    irq_enable_saved  = global_irq_enable;
    global_irq_enable = 1'h0;
  endtask : irq_save

  task automatic irq_restore();
    global_irq_enable = irq_enable_saved;
  endtask : irq_restore
endmodule : spd_core_model

// File: tb_top.sv
// Purpose: Self-checking bench for the special register page decoder.
// Assumes: Each peripheral answers with a byte built from its target code.
// Notes: Expected data is worked out from the target tables, not the design.
`timescale 1ns/1ps
`include "spd_regs.svh"

module tb_top;
  logic                 clk;
  logic                 sys_rst;
  logic [7:0]           sfr_addr;
  logic                 sfr_rd;
  logic                 sfr_wr;
  logic [7:0]           sfr_wdata;
  logic [7:0]           sfr_rdata;
  logic                 sfr_rdata_valid;
  logic [7:0]           periph_rdata;
  spd_pkg::spd_target_t periph_target;
  logic                 periph_rd;
  logic                 periph_wr;
  logic [7:0]           periph_wdata;
  logic [7:0]           page_select;
  int                   mismatches;
  int                   total_checks;

  initial clk = 1'h0;
  always #12.5 clk = ~clk;
  assign periph_rdata = {3'h5, periph_target};

  spd_core_model u_core (.clk(clk), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata));
  spd_page_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
    .periph_rdata(periph_rdata), .periph_target(periph_target), .periph_rd(periph_rd),
    .periph_wr(periph_wr), .periph_wdata(periph_wdata), .page_select(page_select));

  //////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t: byte got %h want %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk_t(input spd_pkg::spd_target_t g, input spd_pkg::spd_target_t e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t: target got %h want %h", $time, g, e);
    end
  endtask : chk_t

  // A page write must not strobe any peripheral.
  task automatic wr_page(input logic [7:0] p);
    if (p == `SPD_PAGE_F)
      u_core.irq_save();
    u_core.issue(1'h0, 1'h1, `SPD_ADDR_PAGE_SEL, p);
    #1;
    chk8({7'h00, periph_wr}, 8'h00);
    u_core.idle();
    #1;
    chk8(page_select, p);
    if (p == `SPD_PAGE_0)
      u_core.irq_restore();
  endtask : wr_page

  task automatic rd_chk(input logic [7:0] a, input spd_pkg::spd_target_t t, input logic [7:0] pg);
    logic [7:0] e;
    logic       hit;
    hit = (t != spd_pkg::SPD_TGT_NONE) && (t != spd_pkg::SPD_TGT_PAGE_SEL);
    e   = (t == spd_pkg::SPD_TGT_NONE) ? 8'h00 : (t == spd_pkg::SPD_TGT_PAGE_SEL) ? pg : {3'h5, t};
    u_core.issue(1'h1, 1'h0, a, 8'h00);
    #1;
    chk_t(periph_target, t);
    chk8({7'h00, periph_rd}, {7'h00, hit});
    u_core.idle();
    #1;
    chk8({7'h00, sfr_rdata_valid}, 8'h01);
    chk8(sfr_rdata, e);
  endtask : rd_chk

  // Writes reach the decoded target with their data intact.
  task automatic wr_chk(input logic [7:0] a, input spd_pkg::spd_target_t t, input logic [7:0] d);
    u_core.issue(1'h0, 1'h1, a, d);
    #1;
    chk_t(periph_target, t);
    chk8({7'h00, periph_wr}, 8'h01);
    chk8(periph_wdata, d);
    u_core.idle();
  endtask : wr_chk

  task automatic t_boot();
    chk8(page_select, `SPD_PAGE_RESET);
    rd_chk(`SPD_ADDR_SCAN_PM, spd_pkg::SPD_TGT_SCAN_END, 8'h00);
  endtask : t_boot

  //////////////////////////////////////////////////////////////////////
  task automatic t_paged();
    logic [7:0]           pa [4];
    spd_pkg::spd_target_t t0 [4];
    spd_pkg::spd_target_t tf [4];
    pa = '{`SPD_ADDR_SCAN_PM, `SPD_ADDR_P0_SBUF, `SPD_ADDR_P1_CPTCN, `SPD_ADDR_P2_CPTMD};
    t0 = '{spd_pkg::SPD_TGT_SCAN_END, spd_pkg::SPD_TGT_SERIAL_BUF, spd_pkg::SPD_TGT_CMP_CONTROL,
      spd_pkg::SPD_TGT_CMP_MODE};
    tf = '{spd_pkg::SPD_TGT_SENSE_PM, spd_pkg::SPD_TGT_PORT0_DRIVE, spd_pkg::SPD_TGT_PORT1_DRIVE,
      spd_pkg::SPD_TGT_PORT2_DRIVE};
    wr_page(8'h0F);
    for (int i = 0; i < 4; i++) rd_chk(pa[i], tf[i], 8'h0F);
    wr_chk(`SPD_ADDR_P1_CPTCN, spd_pkg::SPD_TGT_PORT1_DRIVE, 8'hA5);
    wr_page(8'h00);
    for (int i = 0; i < 4; i++) rd_chk(pa[i], t0[i], 8'h00);
    wr_chk(`SPD_ADDR_P1_CPTCN, spd_pkg::SPD_TGT_CMP_CONTROL, 8'h3C);
    wr_page(8'h55);
    for (int i = 0; i < 4; i++) rd_chk(pa[i], spd_pkg::SPD_TGT_NONE, 8'h55);
  endtask : t_paged

  // Shared registers on both pages and on an undefined page, plus one this decoder leaves alone.
  task automatic t_common();
    logic [7:0]           ca [10];
    spd_pkg::spd_target_t ct [10];
    logic [7:0]           pg [3];
    // Occupied addresses plus 0x80; port 0 latch lies outside this decoder's table.
    ca = '{`SPD_ADDR_IRQ_EN1, `SPD_ADDR_IRQ_EN2, `SPD_ADDR_IRQ_PRI1, `SPD_ADDR_IRQ_PRI2, `SPD_ADDR_FLASH_WR,
      `SPD_ADDR_IREF_CFG, `SPD_ADDR_CRC_CNT, `SPD_ADDR_BURST_PWR, `SPD_ADDR_PAGE_SEL, 8'h80};
    ct = '{spd_pkg::SPD_TGT_IRQ_EN1, spd_pkg::SPD_TGT_IRQ_EN2, spd_pkg::SPD_TGT_IRQ_PRI1,
      spd_pkg::SPD_TGT_IRQ_PRI2, spd_pkg::SPD_TGT_FLASH_WR, spd_pkg::SPD_TGT_IREF_CFG,
      spd_pkg::SPD_TGT_CRC_CNT, spd_pkg::SPD_TGT_BURST_PWR, spd_pkg::SPD_TGT_PAGE_SEL, spd_pkg::SPD_TGT_NONE};
    pg = '{8'h00, 8'h0F, 8'h55};
    for (int p = 0; p < 3; p++)
    begin
      wr_page(pg[p]);
      for (int i = 0; i < 10; i++) rd_chk(ca[i], ct[i], pg[p]);
    end
    wr_page(8'h00);
    wr_chk(`SPD_ADDR_IRQ_EN1, spd_pkg::SPD_TGT_IRQ_EN1, 8'h5A);
  endtask : t_common

  // Page change must reach the access in the very next cycle.
  task automatic t_b2b();
    u_core.irq_save();
    u_core.issue(1'h0, 1'h1, `SPD_ADDR_PAGE_SEL, 8'h0F);
    rd_chk(`SPD_ADDR_P0_SBUF, spd_pkg::SPD_TGT_PORT0_DRIVE, 8'h0F);
    u_core.issue(1'h0, 1'h1, `SPD_ADDR_PAGE_SEL, 8'h00);
    rd_chk(`SPD_ADDR_P0_SBUF, spd_pkg::SPD_TGT_SERIAL_BUF, 8'h00);
    u_core.irq_restore();
  endtask : t_b2b

  task automatic t_rst();
    wr_page(8'h0F);
    @(posedge clk);
    sys_rst <= 1'h1;
    @(posedge clk);
    #1;
    chk8(page_select, `SPD_PAGE_RESET);
    @(posedge clk);
    sys_rst <= 1'h0;
    // Reset leaves the core's interrupt enable cleared from the page 0xF write, so it is restored here.
    u_core.irq_restore();
    rd_chk(`SPD_ADDR_P1_CPTCN, spd_pkg::SPD_TGT_CMP_CONTROL, 8'h00);
  endtask : t_rst

  //////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    sys_rst      = 1'h1;
    mismatches   = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    #1;
    t_boot();
    t_paged();
    t_common();
    t_b2b();
    t_rst();
    give_verdict();
  end
endmodule : tb_top
